// ===== lte_pkg.sv
// Package for the link tuning control register bank.
// Assumes one 125 MHz clock domain and a simple word-wide host register port.
package lte_pkg;

    localparam logic [11:0] LTE_SET_ADDR   = 12'hA88;
    localparam logic [11:0] LTE_CLEAR_ADDR = 12'hA8C;

    localparam int LTE_BIT_PIPE_DIS = 15;
    localparam int LTE_BIT_THR_HI   = 13;
    localparam int LTE_BIT_THR_LO   = 12;
    localparam int LTE_BIT_MPEG     = 10;
    localparam int LTE_BIT_DV       = 8;
    localparam int LTE_BIT_PRIO     = 7;
    localparam int LTE_BIT_ACCEL    = 1;

    // Writable positions: 15, 13, 12, 10, 8, 7, 1
    localparam logic [31:0] LTE_WR_MASK   = 32'h0000B582;
    // Positions that the EEPROM may preload: 7 and 1
    localparam logic [31:0] LTE_ROM_MASK  = 32'h00000082;
    localparam logic [31:0] LTE_RESET_VAL = 32'h00001000;

    localparam logic [7:0] LTE_FMT_MPEG = 8'h20;
    localparam logic [7:0] LTE_FMT_DV   = 8'h00;

    // Transmit FIFO thresholds in bytes
    localparam logic [11:0] LTE_THR_2K   = 12'h800;
    localparam logic [11:0] LTE_THR_1K7  = 12'h6A0;
    localparam logic [11:0] LTE_THR_1K   = 12'h400;
    localparam logic [11:0] LTE_THR_512  = 12'h200;

    localparam int LTE_BUF_DEPTH = 2;

    typedef struct packed {
        logic        pipe_dis;
        logic [1:0]  thresh;
        logic        mpeg_ts;
        logic        dv_ts;
        logic        prio;
        logic        accel;
    } lte_ctrl_s;

    typedef enum logic [1:0] {
        LTE_ST_IDLE = 2'b00,
        LTE_ST_FILL = 2'b01,
        LTE_ST_SEND = 2'b11,
        LTE_ST_SAF  = 2'b10
    } lte_tx_e;

    typedef struct packed {
        logic [31:0] data;
        logic        last;
    } lte_word_s;

endpackage

// ===== lte_buf2.sv
// Two-entry buffer carrying transmit words with an end-of-packet flag.
// Assumes source and sink share clk_sys_in.
`timescale 1ns/10ps
module lte_buf2
    import lte_pkg::*;
(
    input  wire logic      clk_sys_in,
    input  wire logic      sys_rst_in,
    input  wire logic      in_valid_in,
    output logic           in_ready_out,
    input  wire lte_word_s in_word_in,
    output logic           out_valid_out,
    input  wire logic      out_ready_in,
    output lte_word_s      out_word_out
);

    lte_word_s mem_q [LTE_BUF_DEPTH];
    logic      wr_ptr_q;
    logic      rd_ptr_q;
    logic [1:0] count_q;
    logic      push;
    logic      pop;

    assign in_ready_out  = (count_q != 2'h2);
    assign out_valid_out = (count_q != 2'h0);
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_word_out  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_word_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// ===== lte_ctrl.sv
// Link tuning control register bank and asynchronous transmit start gating.
// Assumes host port strobes are one cycle, on clk_sys_in, and that the
// configuration-space alias and the EEPROM loader sit outside this block.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Memory view and configuration alias share one storage register.
// - Set address sets written ones; clear address clears written ones.
// - EEPROM may preload bits 7 and 1 when present.
// - Bits 31 to 16 read as zero.
// - Bit 15 one stops out-of-order async transmit pipelining.
// - Threshold code: 00 2K, 01 1.7K default, 10 1K, 11 512.
// - Programmed threshold used until first underrun; retries use 2K.
// - Below 2K, start at threshold fill or whole packet loaded.
// - After underrun, go store-and-forward; resend only when whole packet held.
// - 2K threshold holds data until end-of-packet token arrives.
// - Zero retries register forces store-and-forward.
// - Bits 14, 11 and 9 are reserved read-only; 11 and 9 read zero.
// - Bit 10 enables MPEG timestamp for format code 20h.
// - Bit 8 enables DV timestamp for format code 00h.
// - Bit 7 lets link answer with priority arbitration.
// - Bit 1 tells the physical layer of acceleration support.
module lte_ctrl
    import lte_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    // Memory-mapped host port
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [11:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic [31:0]      reg_rdata_out,
    output logic             reg_ack_out,
    // Configuration-space alias port
    input  wire logic        cfg_wr_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic [31:0]      cfg_rdata_out,
    // EEPROM preload
    input  wire logic        rom_load_in,
    input  wire logic [31:0] rom_data_in,
    // Transmit context status
    input  wire logic [7:0]  async_tx_retries_in,
    input  wire logic        async_tx_underrun_in,
    input  wire logic        async_tx_retry_in,
    input  wire logic [11:0] async_tx_fill_in,
    input  wire logic [7:0]  stream_format_code_in,
    // Transmit word stream
    input  wire logic        tx_valid_in,
    output logic             tx_ready_out,
    input  wire lte_word_s   tx_word_in,
    output logic             link_valid_out,
    input  wire logic        link_ready_in,
    output lte_word_s        link_word_out,
    // Control outputs
    output lte_ctrl_s        ctrl_out,
    output logic             async_tx_pipeline_disable_out,
    output logic             mpeg_timestamp_enable_out,
    output logic             dv_timestamp_enable_out,
    output logic             priority_arb_enable_out,
    output logic             phy_accel_enable_out,
    output logic             store_forward_out,
    output logic [11:0]      async_tx_threshold_out,
    output logic             tx_start_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers

    function automatic logic [11:0] thr_bytes(input logic [1:0] code);
        case (code)
            2'b00:   thr_bytes = LTE_THR_2K;
            2'b01:   thr_bytes = LTE_THR_1K7;
            2'b10:   thr_bytes = LTE_THR_1K;
            default: thr_bytes = LTE_THR_512;
        endcase
    endfunction

    function automatic logic [31:0] set_bits(input logic [31:0] cur,
                                             input logic [31:0] ones);
        set_bits = cur | (ones & LTE_WR_MASK);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage, one copy for both views

    logic [31:0] tune_q;
    logic [31:0] tune_d;
    logic        hit_set;
    logic        hit_clr;

    assign hit_set = reg_wr_in && (reg_addr_in == LTE_SET_ADDR);
    assign hit_clr = reg_wr_in && (reg_addr_in == LTE_CLEAR_ADDR);

    always_comb begin
        tune_d = tune_q;
        if (rom_load_in) begin
            // Preload only the EEPROM-loadable positions
            tune_d = (tune_d & ~LTE_ROM_MASK) | (rom_data_in & LTE_ROM_MASK);
        end
        if (cfg_wr_in) begin
            tune_d = (tune_d & ~LTE_WR_MASK) | (cfg_wdata_in & LTE_WR_MASK);
        end
        if (hit_set) begin
            tune_d = set_bits(tune_d, reg_wdata_in);
        end
        if (hit_clr) begin
            tune_d = tune_d & ~(reg_wdata_in & LTE_WR_MASK);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            tune_q <= LTE_RESET_VAL;
        end else begin
            tune_q <= tune_d & LTE_WR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reads

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 32'h00000000;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_ack_out <= reg_rd_in || reg_wr_in;
            if (reg_rd_in &&
                ((reg_addr_in == LTE_SET_ADDR) || (reg_addr_in == LTE_CLEAR_ADDR))) begin
                reg_rdata_out <= tune_q & LTE_WR_MASK;
            end else begin
                reg_rdata_out <= 32'h00000000;
            end
        end
    end

    assign cfg_rdata_out = tune_q & LTE_WR_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // Control fields

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ctrl_out <= '0;
        end else begin
            ctrl_out.pipe_dis <= tune_q[LTE_BIT_PIPE_DIS];
            ctrl_out.thresh   <= tune_q[LTE_BIT_THR_HI:LTE_BIT_THR_LO];
            ctrl_out.mpeg_ts  <= tune_q[LTE_BIT_MPEG];
            ctrl_out.dv_ts    <= tune_q[LTE_BIT_DV];
            ctrl_out.prio     <= tune_q[LTE_BIT_PRIO];
            ctrl_out.accel    <= tune_q[LTE_BIT_ACCEL];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            async_tx_pipeline_disable_out <= 1'b0;
            mpeg_timestamp_enable_out     <= 1'b0;
            dv_timestamp_enable_out       <= 1'b0;
            priority_arb_enable_out       <= 1'b0;
            phy_accel_enable_out          <= 1'b0;
        end else begin
            async_tx_pipeline_disable_out <= tune_q[LTE_BIT_PIPE_DIS];
            mpeg_timestamp_enable_out     <= tune_q[LTE_BIT_MPEG] &&
                                             (stream_format_code_in == LTE_FMT_MPEG);
            dv_timestamp_enable_out       <= tune_q[LTE_BIT_DV] &&
                                             (stream_format_code_in == LTE_FMT_DV);
            priority_arb_enable_out       <= tune_q[LTE_BIT_PRIO];
            phy_accel_enable_out          <= tune_q[LTE_BIT_ACCEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Threshold and store-and-forward selection

    logic underrun_seen_q;
    logic saf_now;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            underrun_seen_q <= 1'b0;
        end else if (async_tx_underrun_in) begin
            underrun_seen_q <= 1'b1;
        end
    end

    // Only the underrun term is sticky until reset; retry, zero retries and code 00 apply while present
    assign saf_now = underrun_seen_q || async_tx_underrun_in || async_tx_retry_in ||
                     (async_tx_retries_in == 8'h00) ||
                     (tune_q[LTE_BIT_THR_HI:LTE_BIT_THR_LO] == 2'b00);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            store_forward_out      <= 1'b0;
            async_tx_threshold_out <= LTE_THR_1K7;
        end else begin
            store_forward_out      <= saf_now;
            async_tx_threshold_out <= saf_now ? LTE_THR_2K :
                                      thr_bytes(tune_q[LTE_BIT_THR_HI:LTE_BIT_THR_LO]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit start gating

    lte_tx_e   st_q;
    logic      eop_seen_q;
    logic      buf_valid;
    logic      buf_ready;
    lte_word_s buf_word;
    logic      gate_open;

    lte_buf2 u_buf (
        .clk_sys_in    (clk_sys_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .in_word_in    (tx_word_in),
        .out_valid_out (buf_valid),
        .out_ready_in  (buf_ready),
        .out_word_out  (buf_word)
    );

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            eop_seen_q <= 1'b0;
        end else if (tx_valid_in && tx_ready_out && tx_word_in.last) begin
            eop_seen_q <= 1'b1;
        end else if (link_valid_out && link_ready_in && buf_word.last) begin
            eop_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            st_q <= LTE_ST_IDLE;
        end else begin
            case (st_q)
                LTE_ST_IDLE: begin
                    if (buf_valid) begin
                        st_q <= store_forward_out ? LTE_ST_SAF : LTE_ST_FILL;
                    end
                end
                LTE_ST_FILL: begin
                    // Threshold or whole packet, whichever first
                    if ((async_tx_fill_in >= async_tx_threshold_out) || eop_seen_q) begin
                        st_q <= LTE_ST_SEND;
                    end else if (store_forward_out) begin
                        st_q <= LTE_ST_SAF;
                    end
                end
                LTE_ST_SAF: begin
                    if (eop_seen_q) begin
                        st_q <= LTE_ST_SEND;
                    end
                end
                LTE_ST_SEND: begin
                    if (link_valid_out && link_ready_in && buf_word.last) begin
                        st_q <= LTE_ST_IDLE;
                    end
                end
                default: st_q <= LTE_ST_IDLE;
            endcase
        end
    end

    assign gate_open      = (st_q == LTE_ST_SEND);
    assign link_valid_out = buf_valid && gate_open;
    assign buf_ready      = link_ready_in && gate_open;
    assign link_word_out  = buf_word;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            tx_start_out <= 1'b0;
        end else begin
            tx_start_out <= (st_q != LTE_ST_SEND) && (st_q != LTE_ST_IDLE) &&
                            (((st_q == LTE_ST_FILL) &&
                              (async_tx_fill_in >= async_tx_threshold_out)) || eop_seen_q);
        end
    end

endmodule

// ===== lte_ctrl_checker.sv
// Checker for the link tuning register bank and its gated outputs.
// Assumes it is bound to lte_ctrl and sees only that module's ports.
`timescale 1ns/10ps
module lte_ctrl_checker
    import lte_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        sys_rst_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        reg_ack_out,
    input wire logic        cfg_wr_in,
    input wire logic        rom_load_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic [7:0]  async_tx_retries_in,
    input wire logic [7:0]  stream_format_code_in,
    input wire logic        store_forward_out,
    input wire logic        async_tx_pipeline_disable_out,
    input wire logic        mpeg_timestamp_enable_out,
    input wire logic        link_valid_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // Other writers excluded, since same-cycle priority would blur the check
    wire logic quiet = !cfg_wr_in && !rom_load_in;
    wire logic hit   = reg_addr_in == LTE_SET_ADDR || reg_addr_in == LTE_CLEAR_ADDR;
    ////////////////////////////////////////////////////////////////////////////
    ack_after_req_a: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out)
        else $error("no ack after request");
    no_idle_ack_a: assert property (!(reg_wr_in || reg_rd_in) |=> !reg_ack_out)
        else $error("ack without request");
    upper_zero_a: assert property (reg_ack_out |-> reg_rdata_out[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    rsvd_zero_a: assert property ((cfg_rdata_out & ~LTE_WR_MASK) == 32'h00000000)
        else $error("reserved bit stored");
    set_bits_a: assert property (reg_wr_in && quiet && reg_addr_in == LTE_SET_ADDR |=>
        cfg_rdata_out == ($past(cfg_rdata_out) | ($past(reg_wdata_in) & LTE_WR_MASK)))
        else $error("set write wrong");
    clear_bits_a: assert property (reg_wr_in && quiet && reg_addr_in == LTE_CLEAR_ADDR |=>
        cfg_rdata_out == ($past(cfg_rdata_out) & ~($past(reg_wdata_in) & LTE_WR_MASK)))
        else $error("clear write wrong");
    read_view_a: assert property (reg_rd_in && !reg_wr_in && quiet && hit |=>
        reg_rdata_out == $past(cfg_rdata_out))
        else $error("read differs from storage");
    unmapped_zero_a: assert property (reg_rd_in && !hit |=> reg_rdata_out == 32'h00000000)
        else $error("unmapped read not zero");
    saf_no_retry_a: assert property ((async_tx_retries_in == 8'h00)[*3] |-> store_forward_out)
        else $error("zero retries without store and forward");
    pipe_follow_a: assert property ($stable(cfg_rdata_out[15]) |->
        async_tx_pipeline_disable_out == cfg_rdata_out[15])
        else $error("pipeline disable does not follow bit");
    mpeg_fmt_a: assert property ($stable(cfg_rdata_out[10]) && $stable(stream_format_code_in) |->
        mpeg_timestamp_enable_out == (cfg_rdata_out[10] && stream_format_code_in == LTE_FMT_MPEG))
        else $error("mpeg enable wrong");
    cover property (reg_wr_in && reg_addr_in == LTE_CLEAR_ADDR);
    cover property (reg_rd_in && !hit);
    cover property ($rose(link_valid_out));
endmodule
bind lte_ctrl lte_ctrl_checker chk_u (.clk_sys_in, .sys_rst_in, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .cfg_wr_in, .rom_load_in,
    .cfg_rdata_out, .async_tx_retries_in, .stream_format_code_in, .store_forward_out,
    .async_tx_pipeline_disable_out, .mpeg_timestamp_enable_out, .link_valid_out);

// ===== testbench.sv
// Self-checking bench for the link tuning register bank.
// Assumes lte_pkg, lte_buf2, lte_ctrl and the checker are compiled first.
`timescale 1ns/10ps
module testbench;
    import lte_pkg::*;
    logic clk_sys_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, cfg_wr_in = 0;
    logic rom_load_in = 0, async_tx_underrun_in = 0, async_tx_retry_in = 0;
    logic tx_valid_in = 0, link_ready_in = 0, reg_ack_out, tx_ready_out, link_valid_out;
    logic [11:0] reg_addr_in = 12'h000, async_tx_fill_in = 12'h000, async_tx_threshold_out;
    logic [31:0] reg_wdata_in = 32'h0, cfg_wdata_in = 32'h0, rom_data_in = 32'h0;
    logic [31:0] reg_rdata_out, cfg_rdata_out, m = LTE_RESET_VAL, v;
    logic [7:0]  async_tx_retries_in = 8'h01, stream_format_code_in = 8'h20;
    logic async_tx_pipeline_disable_out, mpeg_timestamp_enable_out, dv_timestamp_enable_out;
    logic priority_arb_enable_out, phy_accel_enable_out, store_forward_out, tx_start_out;
    lte_word_s   tx_word_in = '0, link_word_out, wexp;
    lte_ctrl_s   ctrl_out;
    logic [32:0] rexp;
    logic [32:0] rq[$];
    lte_word_s   wq[$];
    logic [11:0] thr[4] = '{LTE_THR_2K, LTE_THR_1K7, LTE_THR_1K, LTE_THR_512};
    int errors = 0, checks_done = 0, i;
    integer seed = 32'h4ab7;
    always #4 clk_sys_in = ~clk_sys_in;
    lte_ctrl dut_u (.clk_sys_in, .sys_rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
        .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .cfg_wr_in, .cfg_wdata_in, .cfg_rdata_out,
        .rom_load_in, .rom_data_in, .async_tx_retries_in, .async_tx_underrun_in,
        .async_tx_retry_in, .async_tx_fill_in, .stream_format_code_in, .tx_valid_in,
        .tx_ready_out, .tx_word_in, .link_valid_out, .link_ready_in, .link_word_out, .ctrl_out,
        .async_tx_pipeline_disable_out, .mpeg_timestamp_enable_out, .dv_timestamp_enable_out,
        .priority_arb_enable_out, .phy_accel_enable_out, .store_forward_out,
        .async_tx_threshold_out, .tx_start_out);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // One-cycle strobe, then an idle edge so strobes never merge
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= wr; reg_rd_in <= !wr; reg_addr_in <= a; reg_wdata_in <= d;
        if (wr && a == LTE_SET_ADDR) m = m | (d & LTE_WR_MASK);
        else if (wr && a == LTE_CLEAR_ADDR) m = m & ~(d & LTE_WR_MASK);
        rq.push_back({!wr, (a == LTE_SET_ADDR || a == LTE_CLEAR_ADDR) ? m : 32'h0});
        @(posedge clk_sys_in);
        reg_wr_in <= 0; reg_rd_in <= 0;
        #1 if (wr) chk(cfg_rdata_out === m, "alias view");
    endtask
    task automatic push(input lte_word_s w);
        @(posedge clk_sys_in);
        tx_valid_in <= 1; tx_word_in <= w; wq.push_back(w);
        for (int k = 0; k < 50; k++) begin
            @(negedge clk_sys_in);
            if (tx_ready_out === 1'b1) break;
        end
        @(posedge clk_sys_in);
        tx_valid_in <= 0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk_sys_in) begin
        if (reg_ack_out === 1'b1) begin
            rexp = rq.pop_front();
            if (rexp[32]) chk(reg_rdata_out === rexp[31:0], "read data");
        end
        if (link_valid_out === 1'b1 && link_ready_in === 1'b1) begin
            wexp = wq.pop_front();
            chk(link_word_out === wexp, "link word");
        end
    end
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_sys_in);
        sys_rst_in <= 0;
        acc(0, LTE_SET_ADDR, 0);
        acc(0, LTE_CLEAR_ADDR, 0);
        for (i = 0; i < 24; i++) begin
            v = $random(seed);
            acc(1, v[0] ? LTE_SET_ADDR : LTE_CLEAR_ADDR, v);
            acc(0, v[1] ? LTE_SET_ADDR : LTE_CLEAR_ADDR, 0);
        end
        acc(1, 12'hA90, 32'hFFFFFFFF);
        acc(0, 12'hA90, 0);
        @(posedge clk_sys_in) cfg_wr_in <= 1; cfg_wdata_in <= 32'hFFFFFFFF;
        @(posedge clk_sys_in) cfg_wr_in <= 0;
        m = LTE_WR_MASK;
        acc(0, LTE_SET_ADDR, 0);
        @(posedge clk_sys_in) rom_load_in <= 1;
        @(posedge clk_sys_in) rom_load_in <= 0;
        m = m & ~LTE_ROM_MASK;
        acc(0, LTE_CLEAR_ADDR, 0);
        acc(1, LTE_SET_ADDR, LTE_WR_MASK);
        cyc(3);
        chk(async_tx_pipeline_disable_out === 1'b1, "pipe");
        chk(ctrl_out === 7'h7F, "field copy");
        chk(priority_arb_enable_out === 1'b1 && phy_accel_enable_out === 1'b1, "prio");
        chk(mpeg_timestamp_enable_out === 1'b1 && dv_timestamp_enable_out === 1'b0, "mpeg");
        stream_format_code_in <= LTE_FMT_DV;
        cyc(3);
        chk(dv_timestamp_enable_out === 1'b1 && mpeg_timestamp_enable_out === 1'b0, "dv");
        for (i = 0; i < 4; i++) begin
            acc(1, LTE_CLEAR_ADDR, 32'h3000);
            acc(1, LTE_SET_ADDR, i << 12);
            cyc(3);
            chk(async_tx_threshold_out === thr[i], "threshold");
            chk(store_forward_out === (i == 0), "code store");
        end
        // Code 11 left in place: 512 bytes, stalled sink
        push('{32'h11111111, 1'b0});
        cyc(4);
        chk(link_valid_out === 1'b0, "gate early");
        async_tx_fill_in <= LTE_THR_512;
        cyc(1);
        chk(tx_start_out === 1'b1, "start at fill");
        cyc(2);
        chk(tx_start_out === 1'b0, "start ends");
        chk(link_valid_out === 1'b1, "gate at fill");
        push('{32'h22222222, 1'b0});
        cyc(1);
        chk(tx_ready_out === 1'b0, "buffer full");
        link_ready_in <= 1;
        push('{32'h33333333, 1'b1});
        cyc(6);
        chk(wq.size() == 0, "drain");
        acc(1, LTE_CLEAR_ADDR, 32'h3000);
        async_tx_fill_in <= 12'h7FF;
        push('{32'h44444444, 1'b0});
        cyc(4);
        chk(link_valid_out === 1'b0, "store hold");
        push('{32'h55555555, 1'b1});
        cyc(6);
        chk(wq.size() == 0, "store drain");
        acc(1, LTE_SET_ADDR, 32'h3000);
        async_tx_retries_in <= 8'h00;
        cyc(4);
        chk(store_forward_out === 1'b1, "no retries");
        async_tx_retries_in <= 8'h01;
        cyc(4);
        chk(store_forward_out === 1'b0, "retries back");
        async_tx_retry_in <= 1;
        cyc(3);
        chk(store_forward_out === 1'b1, "retry saf");
        async_tx_retry_in <= 0;
        async_tx_underrun_in <= 1;
        @(posedge clk_sys_in) async_tx_underrun_in <= 0;
        cyc(4);
        chk(store_forward_out === 1'b1, "underrun sticky");
        sys_rst_in <= 1;
        cyc(2);
        sys_rst_in <= 0;
        m = LTE_RESET_VAL;
        acc(0, LTE_SET_ADDR, 0);
        cyc(3);
        chk(store_forward_out === 1'b0 && rq.size() == 0, "after reset");
        print_verdict();
    end
endmodule
